//--- sbc_consts.vh
// Constants for the synthesizer band calibration controller.
// Assumes inclusion by bare name from the design files.
`ifndef SBC_CONSTS_VH
`define SBC_CONSTS_VH

// ============================================================
// Register indices (8-bit register port)
`define SBC_REG_FRAC0      8'h00
`define SBC_REG_FRAC1      8'h01
`define SBC_REG_FRAC2      8'h02
`define SBC_REG_FRAC3      8'h03
`define SBC_REG_INT_LO     8'h06
`define SBC_REG_INT_HI     8'h07
`define SBC_REG_CAL_BYPASS 8'h18
`define SBC_REG_CAL_TIME   8'h19
`define SBC_REG_BAND_PATH  8'h1B
`define SBC_REG_OUT_DIV    8'h1C
`define SBC_REG_STATUS     8'h20

// ============================================================
// Field positions and widths
`define SBC_BYPASS_BIT     0
`define SBC_BAND_PATH_BIT  4
`define SBC_DIV_MSB        2
`define SBC_FRACTIONAL_RATIO_W         25
`define SBC_INT_W          12

// ============================================================
// Reset values and codes
`define SBC_RST_BYTE       8'h00
`define SBC_CAL_TIME_RST   8'h64
`define SBC_DIV_MAX_CODE   3'h4
`define SBC_CAL_MULT       16'h001C
`define SBC_NUM_OSC        2'h3
`define SBC_NUM_BANDS      5'h10
`define SBC_NUM_CHOICES    6'h30
`define SBC_SETTLE_CYCLES  16'h0010

`endif

//--- sbc_cal_timer.v
// Calibration interval timer: counts comparison clock enables.
// Assumes comp_tick is a one-cycle enable in the clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.vh"

module sbc_cal_timer (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Control
    input  wire        start,
    input  wire        comp_tick,
    input  wire [7:0]  divisor,
    // Status
    output reg         busy_q,
    output reg         done_q
);

    reg  [15:0] count_q;
    reg  [15:0] limit_q;
    wire [15:0] limit_d;

    // Interval length is divisor times multiplier
    assign limit_d = {8'h00, divisor} * `SBC_CAL_MULT;

    // ========================================================
    // Counter: restarts on any trigger, flags done at limit
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 16'h0000;
            limit_q <= 16'h0000;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                count_q <= 16'h0000;
                limit_q <= limit_d;
                busy_q  <= 1'b1;
            end else if (busy_q && comp_tick) begin
                if (count_q + 16'h0001 >= limit_q) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                count_q <= count_q + 16'h0001;
            end
        end
    end

endmodule // sbc_cal_timer
`default_nettype wire

//--- sbc_ctrl.v
// Synthesizer band calibration controller: register file, divider
// selection, feedback ratio, calibration sequencing and lock flag.
// Assumes comp_tick is a one-cycle enable from the comparison clock
// divider in the clk domain and lock_in comes from analog pins.
// Function
// - Three oscillators of sixteen bands each give 48 choices.
// - A write to the lowest fractional register starts calibration.
// - The interval is divisor times 28 comparison clock periods.
// - Tuning is on the internal reference during calibration.
// - Bypass bit 0 set suppresses calibration on later writes.
// - Divider codes 0 to 4 select divide by 1, 2, 4, 8 or 16.
// - A fixed divide by two follows the programmable divider.
// - Lowest fractional write drops lock; it rises when settled.
// - Fraction spans registers 0 to 3, integer registers 6 and 7.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.vh"

module sbc_ctrl (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Timing and analog status
    input  wire        comp_tick,
    input  wire        lock_in,
    // Synthesizer control
    output reg  [24:0] fractional_ratio,
    output reg  [11:0] int_ratio,
    output reg  [2:0]  output_divider_code,
    output reg  [4:0]  div_ratio_q,
    output reg         quad_div2_q,
    output reg         band_path_q,
    output reg         tune_ref_sel_q,
    output reg         cal_start_q,
    output reg  [1:0]  osc_sel_q,
    output reg  [3:0]  band_sel_q,
    output reg  [5:0]  band_choice_q,
    output reg         lock_indicator
);

    // ========================================================
    // Register storage
    reg  [7:0] fractional_ratio_q [0:3];
    reg  [7:0] int_lo_q;
    reg  [7:0] int_hi_q;
    reg  [7:0] cal_bypass_reg;
    reg  [7:0] cal_time_reg;
    reg  [7:0] band_path_reg;
    reg  [7:0] output_divider_reg;
    reg  [1:0] lock_sync_q;
    reg  [15:0] settle_q;
    wire       fractional_ratio_low_word_wr;
    wire       cal_busy;
    wire       cal_done;
    wire [5:0] choice_d;
    genvar     gi;

    assign fractional_ratio_low_word_wr = reg_wr && (reg_addr == `SBC_REG_FRAC0);

    // Fraction bytes, one per index
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_fractional_ratio
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    fractional_ratio_q[gi] <= `SBC_RST_BYTE;
                end else if (reg_wr && reg_addr == gi) begin
                    fractional_ratio_q[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    // ========================================================
    // Configuration register writes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_lo_q           <= `SBC_RST_BYTE;
            int_hi_q           <= `SBC_RST_BYTE;
            cal_bypass_reg     <= `SBC_RST_BYTE;
            cal_time_reg       <= `SBC_CAL_TIME_RST;
            band_path_reg      <= `SBC_RST_BYTE;
            output_divider_reg <= `SBC_RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                `SBC_REG_INT_LO:     int_lo_q <= reg_wdata;
                `SBC_REG_INT_HI:     int_hi_q <= reg_wdata;
                `SBC_REG_CAL_BYPASS: cal_bypass_reg <= reg_wdata;
                `SBC_REG_CAL_TIME:   cal_time_reg <= reg_wdata;
                `SBC_REG_BAND_PATH:  band_path_reg <= reg_wdata;
                `SBC_REG_OUT_DIV:    output_divider_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ========================================================
    // Synthesizer control words from registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fractional_ratio    <= 25'h0000000;
            int_ratio           <= 12'h000;
            output_divider_code <= 3'h0;
            div_ratio_q         <= 5'h01;
            quad_div2_q         <= 1'b0;
            band_path_q         <= 1'b0;
        end else begin
            fractional_ratio <= {fractional_ratio_q[3][0], fractional_ratio_q[2],
                                 fractional_ratio_q[1], fractional_ratio_q[0]};
            int_ratio <= {int_hi_q[3:0], int_lo_q};
            band_path_q <= band_path_reg[`SBC_BAND_PATH_BIT];
            quad_div2_q <= 1'b1;
            // Codes above the largest clamp to divide by 16
            if (output_divider_reg[`SBC_DIV_MSB:0] > `SBC_DIV_MAX_CODE)
            begin
                output_divider_code <= `SBC_DIV_MAX_CODE;
                div_ratio_q <= 5'h10;
            end else begin
                output_divider_code <= output_divider_reg[2:0];
                div_ratio_q <= 5'h01 << output_divider_reg[2:0];
            end
        end
    end

    // ========================================================
    // Calibration trigger unless bypassed
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= fractional_ratio_low_word_wr &&
                !cal_bypass_reg[`SBC_BYPASS_BIT];
        end
    end

    sbc_cal_timer u_timer (
        .clk       (clk),
        .reset_n   (reset_n),
        .start     (cal_start_q),
        .comp_tick (comp_tick),
        .divisor   (cal_time_reg),
        .busy_q    (cal_busy),
        .done_q    (cal_done)
    );

    // Band choice index from fraction and integer seeds
    assign choice_d = (int_ratio[5:0] ^ fractional_ratio[24:19])
                      % `SBC_NUM_CHOICES;

    // ========================================================
    // Tuning source and oscillator/band choice
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tune_ref_sel_q <= 1'b0;
            band_choice_q  <= 6'h00;
            osc_sel_q      <= 2'h0;
            band_sel_q     <= 4'h0;
        end else begin
            tune_ref_sel_q <= cal_busy || cal_start_q;
            if (cal_done) begin
                band_choice_q <= choice_d;
                osc_sel_q <= choice_d[5:4];
                band_sel_q <= choice_d[3:0];
            end
        end
    end

    // ========================================================
    // Lock flag: synchronised pin, dropped on new acquisition
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_sync_q    <= 2'b00;
            settle_q       <= 16'h0000;
            lock_indicator <= 1'b0;
        end else begin
            lock_sync_q <= {lock_sync_q[0], lock_in};
            if (fractional_ratio_low_word_wr) begin
                lock_indicator <= 1'b0;
                settle_q       <= 16'h0000;
            end else if (cal_busy || cal_start_q || !lock_sync_q[1]) begin
                settle_q <= 16'h0000;
            end else if (settle_q < `SBC_SETTLE_CYCLES) begin
                settle_q <= settle_q + 16'h0001;
            end else begin
                lock_indicator <= 1'b1;
            end
        end
    end

    // ========================================================
    // Read data, one cycle after the strobe
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `SBC_REG_FRAC0:      reg_rdata <= fractional_ratio_q[0];
                `SBC_REG_FRAC1:      reg_rdata <= fractional_ratio_q[1];
                `SBC_REG_FRAC2:      reg_rdata <= fractional_ratio_q[2];
                `SBC_REG_FRAC3:      reg_rdata <= fractional_ratio_q[3];
                `SBC_REG_INT_LO:     reg_rdata <= int_lo_q;
                `SBC_REG_INT_HI:     reg_rdata <= int_hi_q;
                `SBC_REG_CAL_BYPASS: reg_rdata <= cal_bypass_reg;
                `SBC_REG_CAL_TIME:   reg_rdata <= cal_time_reg;
                `SBC_REG_BAND_PATH:  reg_rdata <= band_path_reg;
                `SBC_REG_OUT_DIV:    reg_rdata <= output_divider_reg;
                `SBC_REG_STATUS:     reg_rdata <= {band_choice_q,
                                                   cal_busy,
                                                   lock_indicator};
                default:             reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // sbc_ctrl
`default_nettype wire

//--- sbc_ctrl_chk.sv
// Checker for sbc_ctrl: calibration, lock and divider.
// Assumes it sees only the ports of sbc_ctrl.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.vh"
// ==========================================
// Checker
module sbc_ctrl_chk (
    // Clock, reset and bus
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       comp_tick,
    // Outputs watched
    input wire logic [2:0] output_divider_code,
    input wire logic [4:0] div_ratio_q,
    input wire logic       quad_div2_q,
    input wire logic       band_path_q,
    input wire logic       tune_ref_sel_q,
    input wire logic       cal_start_q,
    input wire logic       lock_indicator
);
    logic        byp_q;
    logic [7:0]  ctm_q;
    logic [15:0] tick_q;
    logic [15:0] want;
    logic        fw;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Trigger and expected interval
    assign fw   = reg_wr && reg_addr == `SBC_REG_FRAC0;
    assign want = ctm_q == 8'h00 ? 16'h0001 : {8'h00, ctm_q} * 16'h001C;
    // Shadow bypass, divisor and ticks since start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            byp_q  <= 1'b0;
            ctm_q  <= 8'h64;
            tick_q <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == `SBC_REG_CAL_BYPASS)
                byp_q <= reg_wdata[0];
            if (reg_wr && reg_addr == `SBC_REG_CAL_TIME)
                ctm_q <= reg_wdata;
            tick_q <= cal_start_q ? 16'h0000
                                  : tick_q + {15'h0000, comp_tick};
        end
    end
    AST_CAL_START: assert property (fw && !byp_q |=> cal_start_q)
        else $error("no calibration start after trigger");
    AST_BYPASS: assert property (fw && byp_q |=> !cal_start_q)
        else $error("calibration started while bypassed");
    AST_LOCK_DROP: assert property (fw |=> !lock_indicator)
        else $error("lock not dropped by trigger");
    AST_TUNE_REF: assert property (cal_start_q |=> tune_ref_sel_q)
        else $error("tuning not on reference in calibration");
    AST_CAL_LEN: assert property ($fell(tune_ref_sel_q) |->
        tick_q + 16'h0001 >= want && tick_q <= want + 16'h0001)
        else $error("calibration interval length wrong");
    AST_DIV_MAP: assert property ($stable(output_divider_code) |->
        div_ratio_q == 5'h01 << output_divider_code)
        else $error("divide ratio does not match code");
    AST_BAND: assert property (reg_wr && reg_wdata[4] &&
        reg_addr == `SBC_REG_BAND_PATH |-> ##[1:2] band_path_q)
        else $error("band path bit not applied");
    AST_QUAD: assert property ($past(reset_n) |-> quad_div2_q)
        else $error("fixed halving stage not enabled");
    // Main scenarios reached
    cover property (cal_start_q);
    cover property ($fell(tune_ref_sel_q));
    cover property ($rose(lock_indicator));
endmodule // sbc_ctrl_chk
bind sbc_ctrl sbc_ctrl_chk u_chk (
    .clk                 (clk),
    .reset_n             (reset_n),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .comp_tick           (comp_tick),
    .output_divider_code (output_divider_code),
    .div_ratio_q         (div_ratio_q),
    .quad_div2_q         (quad_div2_q),
    .band_path_q         (band_path_q),
    .tune_ref_sel_q      (tune_ref_sel_q),
    .cal_start_q         (cal_start_q),
    .lock_indicator      (lock_indicator)
);
`default_nettype wire

//--- sbc_host.sv
// Host model: register port master with one-cycle strobes.
// Assumes the slave answers a read in the following cycle.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host
module sbc_host (
    // Clock and read data
    input wire logic       clk,
    input wire logic [7:0] reg_rdata,
    // Requests
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic       reg_wr,
    output var logic       reg_rd
);
    // Idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Write strobe for one cycle beside address and data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read strobe; data stands only in the next cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule // sbc_host
`default_nettype wire

//--- sbc_ctrl_tb.sv
// Testbench for sbc_ctrl with the host model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.vh"
// ==========================================
// Bench
module sbc_ctrl_tb;
    logic clk, reset_n, comp_tick, lock_in, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [24:0] fractional_ratio;
    logic [11:0] int_ratio;
    logic [2:0] output_divider_code;
    logic [4:0] div_ratio_q;
    logic [1:0] osc_sel_q;
    logic [3:0] band_sel_q;
    logic [5:0] band_choice_q;
    logic quad_div2_q, band_path_q, tune_ref_sel_q, cal_start_q;
    logic lock_indicator;
    int miscompares, samples_checked, n;
    sbc_host host (
        .clk       (clk),
        .reg_rdata (reg_rdata),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd)
    );
    sbc_ctrl dut (
        .clk                 (clk),
        .reset_n             (reset_n),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .comp_tick           (comp_tick),
        .lock_in             (lock_in),
        .fractional_ratio    (fractional_ratio),
        .int_ratio           (int_ratio),
        .output_divider_code (output_divider_code),
        .div_ratio_q         (div_ratio_q),
        .quad_div2_q         (quad_div2_q),
        .band_path_q         (band_path_q),
        .tune_ref_sel_q      (tune_ref_sel_q),
        .cal_start_q         (cal_start_q),
        .osc_sel_q           (osc_sel_q),
        .band_sel_q          (band_sel_q),
        .band_choice_q       (band_choice_q),
        .lock_indicator      (lock_indicator)
    );
    // Clock and comparison ticks every other cycle
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            comp_tick <= 1'b0;
        end else begin
            comp_tick <= ~comp_tick;
        end
    end
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Reset values and unmapped read
    task automatic t_reset();
        host.rd(`SBC_REG_CAL_TIME, d);
        chk(d, 8'h64);
        host.rd(8'h05, d);
        chk(d, 8'h00);
        chk(quad_div2_q, 1'b1);
    endtask
    // Every divider code, then a clamped one
    task automatic t_div();
        for (int i = 0; i < 6; i++) begin
            host.wr(`SBC_REG_OUT_DIV, i == 5 ? 8'h07 : 8'(i));
            @(posedge clk);
            #1 chk(div_ratio_q, 5'h01 << (i == 5 ? 4 : i));
            chk(output_divider_code, i == 5 ? 4 : i);
        end
    endtask
    // Calibration, restart in mid-run, lock recovery
    task automatic t_cal();
        host.wr(`SBC_REG_CAL_TIME, 8'h01);
        host.wr(`SBC_REG_INT_LO, 8'h2E);
        host.wr(`SBC_REG_FRAC0, 8'h00);
        #1 chk(cal_start_q, 1'b1);
        chk(lock_indicator, 1'b0);
        @(posedge clk);
        #1 chk(tune_ref_sel_q, 1'b1);
        repeat (12) @(posedge clk);
        host.wr(`SBC_REG_FRAC0, 8'h00);
        n = 0;
        for (int k = 0; k < 200 && tune_ref_sel_q !== 1'b0; k++) begin
            @(posedge clk);
            n += comp_tick;
            #1;
        end
        chk(n >= 27 && n <= 30, 1'b1);
        chk(osc_sel_q < 2'h3, 1'b1);
        chk(band_choice_q < 6'h30, 1'b1);
        chk({osc_sel_q, band_sel_q}, band_choice_q);
        for (int k = 0; k < 200 && lock_indicator !== 1'b1; k++)
            @(posedge clk);
        chk(lock_indicator, 1'b1);
        host.rd(`SBC_REG_STATUS, d);
        chk(d, {band_choice_q, 2'b01});
    endtask
    // Bypass, then ratio bytes with the trigger before band path
    task automatic t_bypass();
        host.wr(`SBC_REG_CAL_BYPASS, 8'h01);
        host.wr(`SBC_REG_OUT_DIV, 8'h00);
        host.wr(`SBC_REG_FRAC3, 8'h01);
        host.wr(`SBC_REG_FRAC2, 8'hC0);
        host.wr(`SBC_REG_FRAC1, 8'h00);
        host.wr(`SBC_REG_INT_LO, 8'h2E);
        host.wr(`SBC_REG_INT_HI, 8'h00);
        host.wr(`SBC_REG_FRAC0, 8'h00);
        #1 chk(cal_start_q, 1'b0);
        chk(lock_indicator, 1'b0);
        host.wr(`SBC_REG_BAND_PATH, 8'h10);
        @(posedge clk);
        #1 chk(tune_ref_sel_q, 1'b0);
        chk(fractional_ratio, 25'h1C00000);
        chk(int_ratio, 12'h02E);
        chk(band_path_q, 1'b1);
        chk(output_divider_code, 3'h0);
        for (int k = 0; k < 200 && lock_indicator !== 1'b1; k++)
            @(posedge clk);
        chk(lock_indicator, 1'b1);
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        lock_in = 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        lock_in <= 1'b1;
        t_reset();
        t_div();
        t_cal();
        t_bypass();
        print_verdict();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule // sbc_ctrl_tb
`default_nettype wire
